/* File: core/aica_top.sv */
// Eight-channel rate alarm, calibration and offset control with APB registers
//
// Operation
// R1: Release bit rising edge clears latched alarm
// R2: Calibration starts only while request is one
// R3: Host holds request until both references applied
// R4: Early request drop aborts, calibration marked failed
// R5: Low trigger edge calibrates at span low
// R6: Host connects low reference before low trigger
// R7: High trigger edge calibrates at span high
// R8: Host connects high reference before high trigger
// R9: Trigger bits exist only with calibration connection
// R10: Low status shows low reference passed
// R11: High status shows high reference passed
// R12: Offset added to measurement, default zero
// R13: Host prefers offsets inside operating range
// R14: Rate alarm needs enable set, inhibit clear
// R15: Edges found by comparing with previous update
`timescale 1ns/1ns
`default_nettype none
module aica_top
    import aica_pkg::*;
(
    input  wire logic                    sys_clk,     // System clock, 100 MHz
    input  wire logic                    reset,       // Sync reset, high
    input  wire logic                    psel,        // APB select
    input  wire logic                    penable,     // APB access phase
    input  wire logic                    pwrite,      // APB write
    input  wire logic [11:0]             paddr,       // APB byte address
    input  wire logic [DW-1:0]           pwdata,      // APB write data
    output logic      [DW-1:0]           prdata,      // APB read data
    output logic                         pready,      // APB ready
    output logic                         pslverr,     // APB error
    input  wire logic [NCH-1:0][DW-1:0]  meas_value,  // Raw measured values
    input  wire logic [NCH-1:0]          rate_exceed, // Rate limit exceeded
    output logic      [NCH-1:0]          rate_alarm,  // Latched rate alarms
    output logic      [NCH-1:0][DW-1:0]  chan_data    // Corrected channel data
);

    // Whole block state in one record
    typedef struct packed {
        logic                         cal_conn;  // Connection includes calibration
        logic [NCH-1:0][CTRL_W-1:0]   ctrl;      // Per-channel control words
        logic [NCH-1:0][DW-1:0]       offset;    // channel_offset_value
        logic [NCH-1:0]               alarm;     // Latched rate alarms
        logic [NCH-1:0][DW-1:0]       data;      // Reported channel data
        logic [TICK_W-1:0]            tick_cnt;  // Update divider
        logic                         tick;      // Update-cycle pulse
        logic                         pready;
        logic                         pslverr;
        logic [DW-1:0]                prdata;
    } aica_top_s;

    aica_top_s cur;
    aica_top_s next_cur;

    // Submodule wiring
    logic [NCH-1:0][EDGE_W-1:0] edge_level;   // Bits watched for edges
    logic [NCH-1:0][EDGE_W-1:0] edge_rise;    // Rising edges this update
    logic [NCH-1:0]             cal_low;      // Low point passed
    logic [NCH-1:0]             cal_high;     // High point passed
    logic [NCH-1:0]             cal_busy;     // Sequence running
    logic [NCH-1:0]             cal_done;     // Sequence completed
    logic [NCH-1:0]             cal_failed;   // Sequence aborted
    logic [NCH-1:0][DW-1:0]     cal_corr;     // Calibration correction

    // Edge-watched bits gathered per channel
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            edge_level[c][EDGE_REL]  = cur.ctrl[c][CT_RELEASE];
            edge_level[c][EDGE_LOW]  = cur.ctrl[c][CT_LOW_TRIG];
            edge_level[c][EDGE_HIGH] = cur.ctrl[c][CT_HIGH_TRIG];
        end
    end

    // Edges are taken once per update, not per clock (see R15)
    aica_edge_track u_edge (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .update_tick (cur.tick),
        .level       (edge_level),
        .rise        (edge_rise)
    );

    // One calibration sequencer per channel
    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++) begin : g_cal
            aica_chan_cal u_cal (
                .sys_clk     (sys_clk),
                .reset       (reset),
                .update_tick (cur.tick),
                .cal_conn    (cur.cal_conn),
                .cal_request (cur.ctrl[gc][CT_CAL_REQ]),
                .low_rise    (edge_rise[gc][EDGE_LOW]),
                .high_rise   (edge_rise[gc][EDGE_HIGH]),
                .span        (cur.ctrl[gc][SPAN_LSB +: SPAN_W]),
                .meas        (meas_value[gc]),
                .low_passed  (cal_low[gc]),
                .high_passed (cal_high[gc]),
                .busy        (cal_busy[gc]),
                .done        (cal_done[gc]),
                .failed      (cal_failed[gc]),
                .correction  (cal_corr[gc])
            );
        end
    endgenerate

    // Next-state logic: divider, alarms, data path, APB slave
    always_comb begin
        logic          hit;       // Address is mapped
        logic [DW-1:0] rd;        // Read word
        logic [2:0]    ch;        // Addressed channel
        logic          chan_sel;  // Channel block addressed
        logic          wr_fire;   // Write completes this edge
        hit      = 1'b0;
        rd       = '0;
        ch       = paddr[6:4];
        chan_sel = (paddr[11:8] == CHAN_BLOCK_SEL) && !paddr[7] && (paddr[1:0] == 2'h0);
        wr_fire  = psel && penable && cur.pready && pwrite && !cur.pslverr;
        next_cur = cur;

        // Update divider: one pulse per update cycle
        next_cur.tick = 1'b0;
        if (cur.tick_cnt == TICK_LAST) begin
            next_cur.tick_cnt = '0;
            next_cur.tick     = 1'b1;
        end else begin
            next_cur.tick_cnt = cur.tick_cnt + 1'b1;
        end

        // Per-channel alarm latch and data path
        for (int c = 0; c < NCH; c++) begin
            if (!cur.ctrl[c][CT_ALARM_EN] || cur.ctrl[c][CT_INHIBIT]) begin
                // Disabled or inhibited: alarm never asserts (see R14)
                next_cur.alarm[c] = 1'b0;
            end else if (cur.tick && rate_exceed[c]) begin
                // Set wins over a release in the same update
                next_cur.alarm[c] = 1'b1;
            end else if (edge_rise[c][EDGE_REL]) begin
                // Only a 0->1 of the release bit clears (see R1)
                next_cur.alarm[c] = 1'b0;
            end
            if (cur.tick) begin
                // Measurement plus calibration plus offset (see R12)
                next_cur.data[c] = meas_value[c] + cal_corr[c] + cur.offset[c];
            end
        end

        // APB setup phase: decode, answer in the first access cycle
        next_cur.pready  = 1'b0;
        next_cur.pslverr = 1'b0;
        if (psel && !penable && !cur.pready) begin
            if (paddr == GLOBAL_CTRL_OFS) begin
                hit = 1'b1;
                rd[GC_CAL_CONN] = cur.cal_conn;
            end else if (chan_sel) begin
                hit = 1'b1;
                case (paddr[3:2])
                    CH_CTRL_IDX: begin
                        rd[CTRL_W-1:0] = cur.ctrl[ch];
                    end
                    CH_OFFSET_IDX: begin
                        rd = cur.offset[ch];
                    end
                    CH_STATUS_IDX: begin
                        rd[ST_ALARM]  = cur.alarm[ch];
                        rd[ST_LOW]    = cal_low[ch];  // see R10
                        rd[ST_HIGH]   = cal_high[ch]; // see R11
                        rd[ST_BUSY]   = cal_busy[ch];
                        rd[ST_DONE]   = cal_done[ch];
                        rd[ST_FAILED] = cal_failed[ch];
                    end
                    CH_DATA_IDX: begin
                        rd = cur.data[ch];
                    end
                    default: begin
                        hit = 1'b0;
                    end
                endcase
            end
            next_cur.pready  = 1'b1;
            next_cur.pslverr = !hit;
            next_cur.prdata  = hit ? rd : '0;
        end

        // APB write takes effect at the completing edge
        if (wr_fire) begin
            if (paddr == GLOBAL_CTRL_OFS) begin
                next_cur.cal_conn = pwdata[GC_CAL_CONN];
            end else if (chan_sel && paddr[3:2] == CH_CTRL_IDX) begin
                next_cur.ctrl[ch] = pwdata[CTRL_W-1:0] & CTRL_WMASK;
            end else if (chan_sel && paddr[3:2] == CH_OFFSET_IDX) begin
                next_cur.offset[ch] = pwdata;
            end
        end

        // Without calibration connection the trigger bits do not exist (see R9)
        if (!next_cur.cal_conn) begin
            for (int c = 0; c < NCH; c++) begin
                next_cur.ctrl[c] = next_cur.ctrl[c] & ~CAL_TRIG_MASK;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur.cal_conn <= GC_RESET;
            cur.ctrl     <= {NCH{CTRL_RESET}};
            cur.offset   <= {NCH{OFFSET_RESET}};
            cur.alarm    <= '0;
            cur.data     <= '0;
            cur.tick_cnt <= '0;
            cur.tick     <= 1'b0;
            cur.pready   <= 1'b0;
            cur.pslverr  <= 1'b0;
            cur.prdata   <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs come from state flops
    assign prdata     = cur.prdata;
    assign pready     = cur.pready;
    assign pslverr    = cur.pslverr;
    assign rate_alarm = cur.alarm;
    assign chan_data  = cur.data;

endmodule : aica_top
`default_nettype wire

/* File: core/aica_pkg.sv */
// Shared constants and types for the analog input calibration and alarm control block
package aica_pkg;

    // Channel count and data width
    localparam int NCH    = 8;
    localparam int DW     = 32;
    localparam int EDGE_W = 3;           // Edge-watched bits per channel

    // Edge-watched bit positions inside one channel group
    localparam int EDGE_REL  = 0;        // Rate alarm release
    localparam int EDGE_LOW  = 1;        // Low-point trigger
    localparam int EDGE_HIGH = 2;        // High-point trigger

    // Address decode: paddr[11:8] selects the block, paddr[6:4] the channel, paddr[3:2] the word
    localparam logic [11:0] GLOBAL_CTRL_OFS = 12'h000;
    localparam logic [3:0]  CHAN_BLOCK_SEL  = 4'h1;
    localparam logic [1:0]  CH_CTRL_IDX     = 2'h0;
    localparam logic [1:0]  CH_OFFSET_IDX   = 2'h1;
    localparam logic [1:0]  CH_STATUS_IDX   = 2'h2;
    localparam logic [1:0]  CH_DATA_IDX     = 2'h3;

    // Global control fields
    localparam int GC_CAL_CONN = 0;      // Connection type includes calibration
    localparam logic GC_RESET  = 1'b0;

    // Channel control fields
    localparam int CTRL_W        = 12;
    localparam int CT_ALARM_EN   = 0;
    localparam int CT_INHIBIT    = 1;
    localparam int CT_RELEASE    = 2;
    localparam int CT_CAL_REQ    = 3;
    localparam int CT_LOW_TRIG   = 4;
    localparam int CT_HIGH_TRIG  = 5;
    localparam int SPAN_LSB      = 8;
    localparam int SPAN_W        = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET    = 12'h000;
    localparam logic [CTRL_W-1:0] CTRL_WMASK    = 12'hF3F;
    localparam logic [CTRL_W-1:0] CAL_TRIG_MASK = 12'h030;

    // Channel status fields
    localparam int ST_ALARM  = 0;
    localparam int ST_LOW    = 1;
    localparam int ST_HIGH   = 2;
    localparam int ST_BUSY   = 3;
    localparam int ST_DONE   = 4;
    localparam int ST_FAILED = 5;

    // Offset default is 0.0 engineering units
    localparam logic [DW-1:0] OFFSET_RESET = 32'h0000_0000;

    // Reference points per span; plain defaults, one entry per span code
    localparam logic [DW-1:0] LOW_REF_DEFAULT  = 32'h0000_0000;
    localparam logic [DW-1:0] HIGH_REF_DEFAULT = 32'h0000_2710;
    localparam logic [15:0][DW-1:0] SPAN_LOW_REF  = {16{LOW_REF_DEFAULT}};
    localparam logic [15:0][DW-1:0] SPAN_HIGH_REF = {16{HIGH_REF_DEFAULT}};

    // Update cycle timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int UPDATE_TIME_NS = 1000;
    localparam int UPDATE_CYCLES  = UPDATE_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_W         = $clog2(UPDATE_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(UPDATE_CYCLES - 1);

    // Calibration sequencer states
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_RUN  = 3'b010,
        CAL_HOLD = 3'b100
    } aica_cal_state_e;

endpackage : aica_pkg

/* File: core/aica_edge_track.sv */
// Update-cycle edge detector for the per-channel release and trigger bits
`timescale 1ns/1ns
`default_nettype none
module aica_edge_track
    import aica_pkg::*;
(
    input  wire logic                           sys_clk,     // System clock
    input  wire logic                           reset,       // Sync reset, high
    input  wire logic                           update_tick, // Update-cycle pulse
    input  wire logic [NCH-1:0][EDGE_W-1:0]     level,       // Current bit levels
    output logic      [NCH-1:0][EDGE_W-1:0]     rise         // 0->1 seen this update
);

    // State: value held from the previous update
    typedef struct packed {
        logic [NCH-1:0][EDGE_W-1:0] prev;
    } aica_edge_s;

    aica_edge_s cur;
    aica_edge_s next_cur;

    // Compare against last update; one pulse per transition (see R15)
    always_comb begin
        next_cur = cur;
        rise     = '0;
        if (update_tick) begin
            rise          = level & ~cur.prev;
            next_cur.prev = level;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

endmodule : aica_edge_track
`default_nettype wire

/* File: core/aica_chan_cal.sv */
// Two-point calibration sequencer for one channel
`timescale 1ns/1ns
`default_nettype none
module aica_chan_cal
    import aica_pkg::*;
(
    input  wire logic              sys_clk,     // System clock
    input  wire logic              reset,       // Sync reset, high
    input  wire logic              update_tick, // Update-cycle pulse
    input  wire logic              cal_conn,    // Calibration connection type
    input  wire logic              cal_request, // Hold request level
    input  wire logic              low_rise,    // Low-point trigger edge
    input  wire logic              high_rise,   // High-point trigger edge
    input  wire logic [SPAN_W-1:0] span,        // channel_span_select
    input  wire logic [DW-1:0]     meas,        // Raw measured value
    output logic                   low_passed,  // Low reference passed
    output logic                   high_passed, // High reference passed
    output logic                   busy,        // Sequence running
    output logic                   done,        // Last sequence completed
    output logic                   failed,      // Last sequence aborted
    output logic      [DW-1:0]     correction   // Applied correction
);

    // Whole sequencer state
    typedef struct packed {
        aica_cal_state_e state;
        logic            low_passed;
        logic            high_passed;
        logic            done;
        logic            failed;
        logic [DW-1:0]   low_err;      // Low ref minus sample
        logic [DW-1:0]   high_err;     // High ref minus sample
        logic [DW-1:0]   correction;
    } aica_cal_s;

    aica_cal_s cur;
    aica_cal_s next_cur;

    // Sequencer; everything advances on the update cycle only
    always_comb begin
        next_cur = cur;
        if (update_tick) begin
            case (cur.state)
                CAL_IDLE: begin
                    // Start only on request high (see R2)
                    if (cal_request) begin
                        next_cur.state       = CAL_RUN;
                        next_cur.low_passed  = 1'b0; // see R10
                        next_cur.high_passed = 1'b0; // see R11
                        next_cur.done        = 1'b0;
                        next_cur.failed      = 1'b0;
                    end
                end
                CAL_RUN: begin
                    if (!cal_request) begin
                        // Request dropped early: abort, mark failed (see R4)
                        next_cur.state  = CAL_IDLE;
                        next_cur.failed = 1'b1;
                    end else begin
                        // Triggers exist only with calibration connection (see R9)
                        if (low_rise && cal_conn) begin
                            next_cur.low_err    = SPAN_LOW_REF[span] - meas; // see R5
                            next_cur.low_passed = 1'b1;                      // see R10
                        end
                        if (high_rise && cal_conn) begin
                            next_cur.high_err    = SPAN_HIGH_REF[span] - meas; // see R7
                            next_cur.high_passed = 1'b1;                       // see R11
                        end
                        // Both points taken: average the two errors
                        if (next_cur.low_passed && next_cur.high_passed) begin
                            next_cur.correction = DW'(($signed({next_cur.low_err[DW-1], next_cur.low_err})
                                + $signed({next_cur.high_err[DW-1], next_cur.high_err})) >>> 1);
                            next_cur.done  = 1'b1;
                            next_cur.state = CAL_HOLD;
                        end
                    end
                end
                CAL_HOLD: begin
                    // Wait for request release so one request gives one run
                    if (!cal_request) begin
                        next_cur.state = CAL_IDLE;
                    end
                end
                default: begin
                    next_cur.state = CAL_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur <= '{state: CAL_IDLE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from state
    assign low_passed  = cur.low_passed;
    assign high_passed = cur.high_passed;
    assign busy        = (cur.state == CAL_RUN);
    assign done        = cur.done;
    assign failed      = cur.failed;
    assign correction  = cur.correction;

endmodule : aica_chan_cal
`default_nettype wire

/* File: verif/aica_asserts.sv */
// Checker for the calibration and alarm block, bound to its top
`timescale 1ns/1ns
`default_nettype none
module aica_chk
    import aica_pkg::*;
(
    input wire logic                   sys_clk,     // Clock
    input wire logic                   reset,       // Sync reset
    input wire logic                   psel,        // Select
    input wire logic                   penable,     // Access phase
    input wire logic                   pwrite,      // Direction
    input wire logic [11:0]            paddr,       // Address
    input wire logic [DW-1:0]          pwdata,      // Write data
    input wire logic [DW-1:0]          prdata,      // Read data
    input wire logic                   pready,      // Ready
    input wire logic                   pslverr,     // Error
    input wire logic [NCH-1:0][DW-1:0] meas_value,  // Raw values
    input wire logic [NCH-1:0]         rate_exceed, // Over rate
    input wire logic [NCH-1:0]         rate_alarm,  // Latched alarms
    input wire logic [NCH-1:0][DW-1:0] chan_data    // Corrected data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [31:0] since; // Cycles since data last moved
    logic        seen;  // A data move was seen
    // Track update spacing; first move only arms it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            since <= '0;
            seen  <= 1'b0;
        end else if ($changed(chan_data)) begin
            since <= 32'h1;
            seen  <= 1'b1;
        end else begin
            since <= since + 32'h1;
        end
    end
    a_ready_follows: assert property (psel && !penable && !pready |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_err_only_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == '0) else $error("error read not zero");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    a_alarm_cause: assert property (!(|(rate_alarm & ~$past(rate_alarm) & ~$past(rate_exceed))))
        else $error("alarm set without rate excess");
    a_data_period: assert property ($changed(chan_data) && seen |-> since % UPDATE_CYCLES == 0)
        else $error("data moved off the update cycle");
    cover property ($rose(rate_alarm[0]));
    cover property (pslverr);
    cover property ($changed(chan_data[2]));
endmodule : aica_chk
bind aica_top aica_chk u_chk (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_value(meas_value), .rate_exceed(rate_exceed), .rate_alarm(rate_alarm), .chan_data(chan_data));
`default_nettype wire

/* File: verif/aica_host.sv */
// Host controller model: APB master for the tag registers
`timescale 1ns/1ns
`default_nettype none
module aica_host
    import aica_pkg::*;
(
    input  wire logic          sys_clk, // Clock
    output logic               psel,    // Select
    output logic               penable, // Access phase
    output logic               pwrite,  // Direction
    output logic [11:0]        paddr,   // Address
    output logic [DW-1:0]      pwdata,  // Write data
    input  wire logic [DW-1:0] prdata,  // Read data
    input  wire logic          pready,  // Ready
    input  wire logic          pslverr  // Error
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end
    // One transfer; request held until ready is seen at an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [DW-1:0] d,
                        output logic [DW-1:0] q, output logic e);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : aica_host
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the calibration and alarm block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import aica_pkg::*;
    logic                   sys_clk, reset;      // Clock and reset
    logic                   psel, penable;       // APB control
    logic                   pwrite, pready;      // Direction, ready
    logic                   pslverr;             // Error
    logic [11:0]            paddr;               // Address
    logic [DW-1:0]          pwdata, prdata, q;   // Data, last read
    logic                   e;                   // Last error
    logic [NCH-1:0][DW-1:0] meas, chan_data;     // Values
    logic [NCH-1:0]         exceed, rate_alarm;  // Alarm side
    int                     failures, n_compared, cyc; // Counters
    aica_top dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_value(meas), .rate_exceed(exceed), .rate_alarm(rate_alarm), .chan_data(chan_data));
    aica_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Compare and count
    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [DW-1:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [DW-1:0] exp);
        host.xfer(1'b0, a, '0, q, e);
        chk(q, exp);
    endtask : rd
    // Let n update ticks pass; spacing fixed at 100 cycles
    task automatic upd(input int n);
        repeat (n * UPDATE_CYCLES + 5) @(posedge sys_clk);
    endtask : upd
    task automatic t_regs;
        rd(12'h100, 32'h0);
        rd(12'h104, OFFSET_RESET);
        rd(12'h400, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test regs done");
    endtask : t_regs
    // Latch, hold, release, re-arm after release stays high, inhibit
    task automatic t_alarm;
        wr(12'h100, 32'h1);
        exceed[0] <= 1'b1;
        upd(1);
        chk({31'h0, rate_alarm[0]}, 32'h1);
        exceed[0] <= 1'b0;
        upd(2);
        chk({31'h0, rate_alarm[0]}, 32'h1);
        wr(12'h100, 32'h5);
        upd(1);
        chk({31'h0, rate_alarm[0]}, 32'h0);
        exceed[0] <= 1'b1;
        upd(2);
        chk({31'h0, rate_alarm[0]}, 32'h1);
        wr(12'h100, 32'h3);
        upd(1);
        chk({31'h0, rate_alarm[0]}, 32'h0);
        exceed[0] <= 1'b0;
        $display("test alarm done");
    endtask : t_alarm
    task automatic t_offset;
        meas[1] <= 32'h64;
        wr(12'h114, 32'h5);
        upd(1);
        chk(chan_data[1], 32'h69);
        wr(12'h114, 32'hFFFF_FFF9);
        upd(1);
        rd(12'h11C, 32'h5D);
        $display("test offset done");
    endtask : t_offset
    // Triggers refused without the calibration connection, then a full run
    task automatic t_cal;
        wr(12'h120, 32'h30);
        rd(12'h120, 32'h0);
        wr(12'h000, 32'h1);
        meas[2] <= 32'h10;
        wr(12'h120, 32'h8);
        upd(1);
        rd(12'h128, 32'h08);
        wr(12'h120, 32'h18);
        upd(1);
        rd(12'h128, 32'h0A);
        meas[2] <= 32'h2720;
        wr(12'h120, 32'h28);
        upd(1);
        rd(12'h128, 32'h16);
        upd(1);
        chk(chan_data[2], 32'h2710);
        wr(12'h120, 32'h0);
        $display("test cal done");
    endtask : t_cal
    task automatic t_abort;
        rd(12'h138, 32'h0);
        wr(12'h130, 32'h8);
        upd(1);
        rd(12'h138, 32'h08);
        wr(12'h130, 32'h0);
        upd(1);
        rd(12'h138, 32'h20);
        $display("test abort done");
    endtask : t_abort
    task automatic end_of_test;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 10000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        reset = 1'b1;
        meas = '0;
        exceed = '0;
        failures = 0;
        n_compared = 0;
        cyc = 0;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_alarm();
        t_offset();
        t_cal();
        t_abort();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
